// ===== design/dee_consts.svh
// constants for the data nonvolatile memory access block
// Summary of operation
// - array mapped from word address 7FFE00h upward
// - array holds exactly 256 words
// - each location one addressable 16-bit word
// - any word readable and writable during run
// - core never stalled during program or erase
// - control, key and address registers govern cycles
// - bit 15 busy during cycle; software polls
// - key 55h then AAh unlocks control write
// - unlock lasts one instruction cycle only
// - key register write only, reads zero
// - upper byte start/flag, lower byte operation
`ifndef DEE_CONSTS_SVH
`define DEE_CONSTS_SVH
`define DEE_BASE_ADDR    24'h7FFE00
`define DEE_WORDS        256
`define DEE_ADDR_W       8
`define DEE_DATA_W       16
`define DEE_KEY_FIRST    8'h55
`define DEE_KEY_SECOND   8'hAA
`define DEE_REG_CONTROL  4'h0
`define DEE_REG_KEY      4'h1
`define DEE_REG_ADDR     4'h2
`define DEE_REG_DATA     4'h3
`define DEE_BIT_START    15
`define DEE_BIT_ERROR    13
`define DEE_BIT_ENABLE   14
`define DEE_OP_LSB       0
`define DEE_OP_W         6
`define DEE_OP_WRITE     6'h04
`define DEE_OP_ERASE     6'h18
`define DEE_CTRL_RESET   16'h0000
`define DEE_ERASED       16'hFFFF
`define DEE_PROG_NS      40000
`define DEE_CLK_NS       10
`endif

// ===== design/dee_pkg.sv
// types for the data nonvolatile memory access block
package dee_pkg;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  sel;
		logic [15:0] wdata;
	} dee_reg_req_t;
	typedef struct packed {
		logic        rd;
		logic [23:0] addr;
	} dee_mem_req_t;
	typedef enum logic [1:0] {dee_idle, dee_busy, dee_done} dee_state_t;
endpackage

// ===== design/dee_unlock.sv
// key sequence tracker giving a one-cycle control write window
`include "dee_consts.svh"
module dee_unlock (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       key_wr,
	input  wire logic [7:0] key_data,
	input  wire logic       any_wr,
	output logic            window
);
	logic got_first;
	wire  is_first  = key_wr && key_data == `DEE_KEY_FIRST;
	wire  is_second = key_wr && key_data == `DEE_KEY_SECOND && got_first;
	always_ff @(posedge clock) begin
		if (rst) begin
			got_first <= 1'b0;
			window    <= 1'b0;
		end else begin
			got_first <= is_first;
			window    <= is_second && any_wr;
		end
	end
endmodule

// ===== design/dee_top.sv
// data nonvolatile memory array with control, key and address registers
`include "dee_consts.svh"
module dee_top #(
	parameter int PROG_CYCLES =
		(`DEE_PROG_NS + `DEE_CLK_NS - 1) / `DEE_CLK_NS
) (
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire dee_pkg::dee_reg_req_t reg_req,
	output logic [15:0]              reg_rdata,
	input  wire dee_pkg::dee_mem_req_t mem_req,
	output logic [15:0]              mem_rdata,
	output logic                     mem_hit,
	output logic                     busy
);
	import dee_pkg::*;

	// storage words, left unknown by reset
	logic [`DEE_DATA_W-1:0] array [`DEE_WORDS];

	// software visible registers
	logic [`DEE_DATA_W-1:0] nvm_control_reg;
	logic [`DEE_ADDR_W-1:0] nvm_target_address_reg;
	logic [`DEE_DATA_W-1:0] latch_data;

	// cycle sequencer
	dee_state_t             state;
	dee_state_t             next_state;
	logic [31:0]            cnt;
	logic [31:0]            next_cnt;
	logic                   next_busy;
	logic                   window;

	// read and control paths
	logic [`DEE_DATA_W-1:0] next_rdata;
	logic [`DEE_DATA_W-1:0] next_control;

	// register select decode
	wire sel_ctl = reg_req.sel == `DEE_REG_CONTROL;
	wire sel_key = reg_req.sel == `DEE_REG_KEY;
	wire sel_adr = reg_req.sel == `DEE_REG_ADDR;
	wire sel_dat = reg_req.sel == `DEE_REG_DATA;

	// sequencer state decode
	wire is_idle = state == dee_idle;
	wire is_busy = state == dee_busy;
	wire is_done = state == dee_done;

	// write strobes; address and data frozen while a cycle runs
	wire key_wr = reg_req.wr && sel_key;
	wire adr_wr = reg_req.wr && sel_adr && is_idle;
	wire dat_wr = reg_req.wr && sel_dat && is_idle;

	// control accepted only in the unlock window and while idle
	wire ctl_wr = reg_req.wr && sel_ctl && window && is_idle;
	wire start  = ctl_wr && reg_req.wdata[`DEE_BIT_START];

	// operation select in the lower byte
	wire [`DEE_OP_W-1:0] op;
	assign op = nvm_control_reg[`DEE_OP_LSB +: `DEE_OP_W];
	wire op_write = op == `DEE_OP_WRITE;
	wire op_erase = op == `DEE_OP_ERASE;
	wire op_ok    = op_write || op_erase;

	// cycle length
	wire last_cnt = cnt == 32'(PROG_CYCLES - 1);
	wire finish   = is_busy && last_cnt;

	// array write path
	wire                   arr_we   = finish && op_ok;
	wire [`DEE_DATA_W-1:0] arr_wdat = op_write ? latch_data : `DEE_ERASED;

	// array read path, low address bits index the word
	wire in_range = mem_req.addr >= `DEE_BASE_ADDR;
	wire mem_rd   = mem_req.rd && in_range;
	wire [`DEE_ADDR_W-1:0] mem_idx = mem_req.addr[`DEE_ADDR_W-1:0];
	wire [`DEE_DATA_W-1:0] next_mem_rdata = mem_rd ? array[mem_idx] : '0;
	wire [`DEE_DATA_W-1:0] next_reg_rdata = reg_req.rd ? next_rdata : '0;

	// register read select
	always_comb begin
		if (sel_ctl)
			next_rdata = nvm_control_reg;
		else if (sel_adr)
			next_rdata = {{(`DEE_DATA_W-`DEE_ADDR_W){1'b0}},
				nvm_target_address_reg};
		else if (sel_dat)
			next_rdata = latch_data;
		else
			next_rdata = '0;
	end

	// sequencer next state
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_busy  = busy;
		case (state)
			dee_idle: begin
				if (start) begin
					next_state = dee_busy;
					next_cnt   = '0;
					next_busy  = 1'b1;
				end
			end
			dee_busy: begin
				next_cnt = cnt + 32'h1;
				if (last_cnt)
					next_state = dee_done;
			end
			default: begin
				next_state = dee_idle;
				next_busy  = 1'b0;
			end
		endcase
	end

	// control word: hardware clears start and logs the result
	always_comb begin
		next_control = nvm_control_reg;
		if (ctl_wr)
			next_control = reg_req.wdata;
		else if (is_done) begin
			next_control[`DEE_BIT_START] = 1'b0;
			next_control[`DEE_BIT_ERROR] = !op_ok;
		end
	end

	// key pair tracker
	dee_unlock dee_unlock_i (
		.clock    (clock),
		.rst      (rst),
		.key_wr   (key_wr),
		.key_data (reg_req.wdata[7:0]),
		.any_wr   (reg_req.wr),
		.window   (window)
	);

	// sequencer state
	always_ff @(posedge clock) begin
		if (rst)
			state <= dee_idle;
		else
			state <= next_state;
	end

	// cycle counter
	always_ff @(posedge clock) begin
		if (rst)
			cnt <= '0;
		else
			cnt <= next_cnt;
	end

	// busy flag, mirrors the start bit
	always_ff @(posedge clock) begin
		if (rst)
			busy <= 1'b0;
		else
			busy <= next_busy;
	end

	// control register
	always_ff @(posedge clock) begin
		if (rst)
			nvm_control_reg <= `DEE_CTRL_RESET;
		else
			nvm_control_reg <= next_control;
	end

	// target address register
	always_ff @(posedge clock) begin
		if (rst)
			nvm_target_address_reg <= '0;
		else if (adr_wr)
			nvm_target_address_reg <= reg_req.wdata[`DEE_ADDR_W-1:0];
	end

	// write data latch
	always_ff @(posedge clock) begin
		if (rst)
			latch_data <= '0;
		else if (dat_wr)
			latch_data <= reg_req.wdata;
	end

	// array update at the end of a cycle
	always_ff @(posedge clock) begin
		if (arr_we)
			array[nvm_target_address_reg] <= arr_wdat;
	end

	// register read data
	always_ff @(posedge clock) begin
		if (rst)
			reg_rdata <= '0;
		else
			reg_rdata <= next_reg_rdata;
	end

	// array read data
	always_ff @(posedge clock) begin
		if (rst)
			mem_rdata <= '0;
		else
			mem_rdata <= next_mem_rdata;
	end

	// array hit flag
	always_ff @(posedge clock) begin
		if (rst)
			mem_hit <= 1'b0;
		else
			mem_hit <= mem_rd;
	end

endmodule

// ===== dv/dee_top_props.sv
// port assertions for the memory access block
module dee_top_props #(
	parameter int PROG_CYCLES = 5
) (
	input wire logic                   clock,
	input wire logic                   rst,
	input wire dee_pkg::dee_reg_req_t  reg_req,
	input wire logic [15:0]            reg_rdata,
	input wire dee_pkg::dee_mem_req_t  mem_req,
	input wire logic [15:0]            mem_rdata,
	input wire logic                   mem_hit,
	input wire logic                   busy
);
	timeunit 1ns;
	timeprecision 1ps;
	import dee_pkg::*;
	logic [15:0] bc;
	wire wk = reg_req.wr && reg_req.sel == 4'h1;
	wire k55 = wk && reg_req.wdata[7:0] == 8'h55;
	wire kaa = wk && reg_req.wdata[7:0] == 8'hAA;
	wire cw = reg_req.wr && reg_req.sel == 4'h0 && reg_req.wdata[15];
	always_ff @(posedge clock) bc <= rst ? 16'h0 : busy ? bc + 16'h1 : 16'h0;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_START: assert property (k55 ##1 kaa ##1 (cw && !busy) |=> busy)
		else $error("start missed");
	AST_LOCK: assert property (cw && !busy &&
		!($past(kaa) && $past(k55, 2)) |=> !busy) else $error("locked start");
	AST_ORDER: assert property (
		(kaa && !$past(k55)) ##1 (cw && !busy) |=> !busy) else $error("order");
	AST_LEN: assert property ($fell(busy) |->
		bc >= PROG_CYCLES && bc <= PROG_CYCLES + 1) else $error("busy length");
	AST_KEYRD: assert property (reg_req.rd && reg_req.sel == 4'h1
		|=> reg_rdata == 16'h0000) else $error("key readable");
	AST_IDLE: assert property (!reg_req.rd |=> reg_rdata == 16'h0000)
		else $error("stray read data");
	AST_BIT15: assert property (reg_req.rd && reg_req.sel == 4'h0
		|=> reg_rdata[15] == $past(busy)) else $error("bit 15");
	AST_HIT: assert property (mem_req.rd |=>
		mem_hit == ($past(mem_req.addr) >= 24'h7FFE00)) else $error("hit");
endmodule
bind dee_top dee_top_props #(.PROG_CYCLES(PROG_CYCLES)) dee_top_props_i (
	.clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.mem_req(mem_req), .mem_rdata(mem_rdata), .mem_hit(mem_hit), .busy(busy));

// ===== dv/dee_top_bench.sv
// self-checking bench for the memory access block
module dee_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dee_pkg::*;
	logic clock, rst, mem_hit, busy;
	logic [15:0] reg_rdata, mem_rdata;
	dee_reg_req_t reg_req;
	dee_mem_req_t mem_req;
	int n_fail, checks_done, cyc;
	dee_top #(.PROG_CYCLES(5)) dee_top_i (.clock(clock), .rst(rst),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .mem_hit(mem_hit), .busy(busy));
	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	task chk(logic [15:0] a, logic [15:0] e);
		checks_done++;
		if (a !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h want %h", $time, a, e);
		end
	endtask
	task final_report;
		if (n_fail == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task wr(logic [3:0] s, logic [15:0] d);
		@(posedge clock) reg_req <= {2'h2, s, d};
	endtask
	task idle;
		@(posedge clock) reg_req <= '0;
		#1;
	endtask
	task rd(logic [3:0] s);
		@(posedge clock) reg_req <= {2'h1, s, 16'h0000};
		idle;
	endtask
	task mr(logic [23:0] a);
		@(posedge clock) mem_req <= {1'h1, a};
		@(posedge clock) mem_req <= '0;
		#1;
	endtask
	task go(logic [15:0] op);
		wr(4'h1, 16'h0055);
		wr(4'h1, 16'h00AA);
		wr(4'h0, op);
		idle;
		idle;
	endtask
	task wt;
		repeat (20) begin
			@(posedge clock);
			if (busy === 1'h0) break;
		end
		chk(busy, 16'h0000);
	endtask
	task t_prog;
		wr(4'h2, 16'h0003);
		wr(4'h3, 16'h1234);
		go(16'h8004);
		chk(busy, 16'h0001);
		mr(24'h7FFE03);
		chk(mem_hit, 16'h0001);
		rd(4'h0);
		chk(reg_rdata[15], 16'h0001);
		wt;
		rd(4'h0);
		chk(reg_rdata[13], 16'h0000);
		mr(24'h7FFE03);
		chk(mem_rdata, 16'h1234);
	endtask
	task t_erase;
		wr(4'h2, 16'h00FF);
		go(16'h8018);
		wt;
		mr(24'h7FFEFF);
		chk(mem_rdata, 16'hFFFF);
		mr(24'h7FFDFF);
		chk(mem_hit, 16'h0000);
	endtask
	task t_lock;
		wr(4'h1, 16'h00AA);
		wr(4'h1, 16'h0055);
		wr(4'h0, 16'h8004);
		idle;
		chk(busy, 16'h0000);
		wr(4'h1, 16'h0055);
		wr(4'h1, 16'h00AA);
		wr(4'h2, 16'h0000);
		wr(4'h0, 16'h8004);
		idle;
		chk(busy, 16'h0000);
	endtask
	task t_err;
		go(16'h8001);
		wt;
		rd(4'h0);
		chk(reg_rdata[13], 16'h0001);
		rd(4'h1);
		chk(reg_rdata, 16'h0000);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			final_report;
		end
	end
	initial begin
		reg_req = '0;
		mem_req = '0;
		rst = 1'h1;
		repeat (12) @(posedge clock);
		rst <= 1'h0;
		t_prog;
		t_erase;
		t_lock;
		t_err;
		final_report;
	end
endmodule
